// [mii_tx_pkg.sv]
// Functional notes
// - TXC runs with a 400 ns period, 200 ns high and 200 ns low.
// - MAC holds TXD and TXEN steady at TXC rise; device samples both there.
// - CRS rises 4 bit times after TXEN is sampled high.
// - CRS falls 8 bit times after TXEN is sampled low.
// - With SQE test on, COL pulse starts 2.5 us after TXEN is sampled low.
// - The COL heartbeat lasts 1.0 us, then COL returns low.
// - Heartbeat only when SQE test enable is 1 as TXEN is sampled low; enable resets to 0.
`default_nettype none
package mii_tx_pkg;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TXC_PERIOD_NS  = 400;
    localparam int TXC_HIGH_NS    = 200;
    localparam int BIT_TIME_NS    = 100;
    localparam int CRS_ON_BITS    = 4;
    localparam int CRS_OFF_BITS   = 8;
    localparam int SQE_DELAY_NS   = 2500;
    localparam int SQE_PULSE_NS   = 1000;

    localparam int TXC_PERIOD_CYC = (TXC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TXC_HIGH_CYC   = (TXC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYC        = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CRS_ON_CYC     = CRS_ON_BITS * BIT_CYC;
    localparam int CRS_OFF_CYC    = CRS_OFF_BITS * BIT_CYC;
    localparam int SQE_DELAY_CYC  = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SQE_PULSE_CYC  = (SQE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W          = 9;
    localparam int TXC_CNT_W      = 6;

    localparam logic [3:0] NIBBLE_RST = 4'h0;

    typedef enum logic [1:0] {
        SQE_IDLE,
        SQE_WAIT,
        SQE_PULSE
    } sqe_state_t;
endpackage
`default_nettype wire

// [txc_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module txc_gen (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Generated link clock
    output logic      txc,
    output logic      txc_rise
);
    logic [mii_tx_pkg::TXC_CNT_W-1:0] cnt_ff;
    logic [mii_tx_pkg::TXC_CNT_W-1:0] nxt_cnt;
    logic                             txc_ff;
    logic                             nxt_txc;
    logic                             rise_ff;
    logic                             nxt_rise;

    always_comb begin
        if (cnt_ff == mii_tx_pkg::TXC_CNT_W'(mii_tx_pkg::TXC_PERIOD_CYC - 1)) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        nxt_txc  = (nxt_cnt < mii_tx_pkg::TXC_CNT_W'(mii_tx_pkg::TXC_HIGH_CYC));
        nxt_rise = nxt_txc && !txc_ff;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= mii_tx_pkg::TXC_CNT_W'(mii_tx_pkg::TXC_PERIOD_CYC - 1);
            txc_ff  <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            txc_ff  <= nxt_txc;
            rise_ff <= nxt_rise;
        end
    end

    assign txc      = txc_ff;
    assign txc_rise = rise_ff;
endmodule
`default_nettype wire

// [mii_tx_10m_carrier_sqe.sv]
`timescale 1ns/10ps
`default_nettype none
module mii_tx_10m_carrier_sqe (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    // MAC transmit side
    input  wire logic       TXEN,
    input  wire logic [3:0] TXD,
    output logic            TXC,
    output logic            CRS,
    output logic            COL,
    // Control
    input  wire logic       SQE_TEST_EN,
    // Captured data toward the line
    output logic [3:0]      TX_NIBBLE,
    output logic            TX_NIBBLE_VALID
);
    localparam logic [mii_tx_pkg::CNT_W-1:0] CRS_ON_LD  =
        mii_tx_pkg::CNT_W'(mii_tx_pkg::CRS_ON_CYC);
    localparam logic [mii_tx_pkg::CNT_W-1:0] CRS_OFF_LD =
        mii_tx_pkg::CNT_W'(mii_tx_pkg::CRS_OFF_CYC);
    localparam logic [mii_tx_pkg::CNT_W-1:0] SQE_DLY_LD =
        mii_tx_pkg::CNT_W'(mii_tx_pkg::SQE_DELAY_CYC);
    localparam logic [mii_tx_pkg::CNT_W-1:0] SQE_PLS_LD =
        mii_tx_pkg::CNT_W'(mii_tx_pkg::SQE_PULSE_CYC);
    localparam logic [mii_tx_pkg::CNT_W-1:0] CNT_ONE    = 9'h001;

    logic                            txc_int;
    logic                            txc_rise;

    // Synchronisers; MAC drives TXEN and TXD off the pin clock, SQE_TEST_EN is a control input
    logic [5:0]                      sync1_ff;
    logic [5:0]                      sync2_ff;
    logic                            sqe_en_ff;

    logic                            txen_ff;
    logic                            nxt_txen;
    logic [3:0]                      nib_ff;
    logic [3:0]                      nxt_nib;
    logic                            nib_vld_ff;
    logic                            nxt_nib_vld;
    logic                            txen_up;
    logic                            txen_down;

    logic                            crs_ff;
    logic                            nxt_crs;
    logic [mii_tx_pkg::CNT_W-1:0]    on_cnt_ff;
    logic [mii_tx_pkg::CNT_W-1:0]    nxt_on_cnt;
    logic [mii_tx_pkg::CNT_W-1:0]    off_cnt_ff;
    logic [mii_tx_pkg::CNT_W-1:0]    nxt_off_cnt;

    mii_tx_pkg::sqe_state_t          sqe_st_ff;
    mii_tx_pkg::sqe_state_t          nxt_sqe_st;
    logic [mii_tx_pkg::CNT_W-1:0]    sqe_cnt_ff;
    logic [mii_tx_pkg::CNT_W-1:0]    nxt_sqe_cnt;
    logic                            col_ff;
    logic                            nxt_col;

    txc_gen u_txc_gen (
        .sys_clk  (SYS_CLK),
        .rst      (RST),
        .txc      (txc_int),
        .txc_rise (txc_rise)
    );

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1_ff  <= 6'h00;
            sync2_ff  <= 6'h00;
            sqe_en_ff <= 1'b0;
        end else begin
            sync1_ff  <= {SQE_TEST_EN, TXEN, TXD};
            sync2_ff  <= sync1_ff;
            sqe_en_ff <= sync2_ff[5];
        end
    end

    // Sample at the TXC rise; MAC has a whole cycle to settle, so sync lag is harmless
    always_comb begin
        nxt_txen    = txen_ff;
        nxt_nib     = nib_ff;
        nxt_nib_vld = 1'b0;
        if (txc_rise) begin
            nxt_txen    = sync2_ff[4];
            nxt_nib     = sync2_ff[3:0];
            nxt_nib_vld = sync2_ff[4];
        end
        txen_up   = txc_rise && sync2_ff[4] && !txen_ff;
        txen_down = txc_rise && !sync2_ff[4] && txen_ff;
    end

    // Carrier echo; a frame end seen in the cycle CRS is due to rise does not cancel the rise
    always_comb begin
        nxt_crs     = crs_ff;
        nxt_on_cnt  = on_cnt_ff;
        nxt_off_cnt = off_cnt_ff;
        if (on_cnt_ff != '0) begin
            nxt_on_cnt = on_cnt_ff - 1'b1;
            if (on_cnt_ff == CNT_ONE) begin
                nxt_crs = 1'b1;
            end
        end
        if (off_cnt_ff != '0) begin
            nxt_off_cnt = off_cnt_ff - 1'b1;
            if (off_cnt_ff == CNT_ONE) begin
                nxt_crs = 1'b0;
            end
        end
        if (txen_up) begin
            nxt_on_cnt  = CRS_ON_LD;
            nxt_off_cnt = '0;
        end
        if (txen_down) begin
            nxt_off_cnt = CRS_OFF_LD;
            nxt_on_cnt  = '0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            txen_ff    <= 1'b0;
            nib_ff     <= mii_tx_pkg::NIBBLE_RST;
            nib_vld_ff <= 1'b0;
            crs_ff     <= 1'b0;
            on_cnt_ff  <= '0;
            off_cnt_ff <= '0;
        end else begin
            txen_ff    <= nxt_txen;
            nib_ff     <= nxt_nib;
            nib_vld_ff <= nxt_nib_vld;
            crs_ff     <= nxt_crs;
            on_cnt_ff  <= nxt_on_cnt;
            off_cnt_ff <= nxt_off_cnt;
        end
    end

    // Heartbeat; a new frame does not abort one already scheduled
    always_comb begin
        nxt_sqe_st  = sqe_st_ff;
        nxt_sqe_cnt = sqe_cnt_ff;
        nxt_col     = col_ff;
        case (sqe_st_ff)
            mii_tx_pkg::SQE_IDLE: begin
                nxt_col = 1'b0;
                if (txen_down && sqe_en_ff) begin
                    nxt_sqe_st  = mii_tx_pkg::SQE_WAIT;
                    nxt_sqe_cnt = SQE_DLY_LD;
                end
            end
            mii_tx_pkg::SQE_WAIT: begin
                nxt_sqe_cnt = sqe_cnt_ff - 1'b1;
                if (sqe_cnt_ff == CNT_ONE) begin
                    nxt_sqe_st  = mii_tx_pkg::SQE_PULSE;
                    nxt_sqe_cnt = SQE_PLS_LD;
                    nxt_col     = 1'b1;
                end
            end
            mii_tx_pkg::SQE_PULSE: begin
                nxt_sqe_cnt = sqe_cnt_ff - 1'b1;
                if (sqe_cnt_ff == CNT_ONE) begin
                    nxt_sqe_st  = mii_tx_pkg::SQE_IDLE;
                    nxt_col     = 1'b0;
                end
            end
            default: begin
                nxt_sqe_st  = mii_tx_pkg::SQE_IDLE;
                nxt_sqe_cnt = '0;
                nxt_col     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sqe_st_ff  <= mii_tx_pkg::SQE_IDLE;
            sqe_cnt_ff <= '0;
            col_ff     <= 1'b0;
        end else begin
            sqe_st_ff  <= nxt_sqe_st;
            sqe_cnt_ff <= nxt_sqe_cnt;
            col_ff     <= nxt_col;
        end
    end

    assign TXC             = txc_int;
    assign CRS             = crs_ff;
    assign COL             = col_ff;
    assign TX_NIBBLE       = nib_ff;
    assign TX_NIBBLE_VALID = nib_vld_ff;
endmodule
`default_nettype wire

// [mii_tx_props.sv]
`timescale 1ns/10ps
`default_nettype none
module mii_tx_props (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Watched device pins
    input wire logic TXC,
    input wire logic CRS,
    input wire logic COL,
    input wire logic SQE_TEST_EN,
    input wire logic TX_NIBBLE_VALID
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [8:0] col_len_ff;
    logic [8:0] off_len_ff;
    // off_len_ff saturates, so a long idle cannot wrap into a false window
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            col_len_ff <= 9'h000;
            off_len_ff <= 9'h000;
        end else begin
            col_len_ff <= COL ? col_len_ff + 9'h001 : 9'h000;
            off_len_ff <= SQE_TEST_EN ? 9'h000 : off_len_ff + {8'h00, off_len_ff != 9'h1FF};
        end
    end
    a_txc_shape: assert property ($rose(TXC) |-> ##20 $fell(TXC) ##20 $rose(TXC))
        else $error("TXC period or duty wrong");
    a_valid_place: assert property (TX_NIBBLE_VALID |->
        TXC && $past(TXC) && !$past(TXC, 2))
        else $error("nibble strobe not tied to TXC rise");
    a_valid_pulse: assert property (TX_NIBBLE_VALID |=> !TX_NIBBLE_VALID)
        else $error("nibble strobe longer than one cycle");
    a_crs_on: assert property ($rose(CRS) |-> $past(TX_NIBBLE_VALID, 40))
        else $error("CRS rise latency wrong");
    a_crs_off: assert property ($fell(CRS) |->
        $past(TX_NIBBLE_VALID, 120) && !$past(TX_NIBBLE_VALID, 80))
        else $error("CRS fall latency wrong");
    a_hb_start: assert property ($rose(COL) |->
        $past(TX_NIBBLE_VALID, 290) && !$past(TX_NIBBLE_VALID, 250))
        else $error("heartbeat start delay wrong");
    a_hb_width: assert property ($rose(COL) |-> ##100 $fell(COL))
        else $error("heartbeat does not end on time");
    a_hb_len: assert property ($fell(COL) |-> col_len_ff == 9'h064)
        else $error("heartbeat length wrong");
    a_sqe_gate: assert property (off_len_ff == 9'h1FF |-> !$rose(COL))
        else $error("heartbeat while test disabled");
    c_crs_on: cover property ($rose(CRS));
    c_crs_off: cover property ($fell(CRS));
    c_heartbeat: cover property ($rose(COL));
endmodule
bind mii_tx_10m_carrier_sqe mii_tx_props PROPS (.SYS_CLK(SYS_CLK), .RST(RST), .TXC(TXC), .CRS(CRS),
    .COL(COL), .SQE_TEST_EN(SQE_TEST_EN), .TX_NIBBLE_VALID(TX_NIBBLE_VALID));
`default_nettype wire

// [mac_tx_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_tx_model (
    // Link clock from the device
    input  wire logic  txc,
    // Transmit signals toward the device
    output logic       txen,
    output logic [3:0] txd
);
    logic [4:0] q[$];
    logic [4:0] ent;
    initial begin
        txen = 1'b0;
        txd = 4'h0;
    end
    // Change just after the rise, hold for the whole period
    always @(posedge txc) begin
        #2;
        if (q.size() != 0) begin
            ent = q.pop_front();
            txen = ent[4];
            txd = ent[3:0];
        end else begin
            txen = 1'b0;
            // Idle data is junk, never a copy of the last nibble
            txd = ~txd;
        end
    end
endmodule
`default_nettype wire

// [mii_tx_10m_carrier_sqe_test.sv]
`timescale 1ns/10ps
`default_nettype none
module mii_tx_10m_carrier_sqe_test;
    logic sys_clk, rst, sqe_en, txc, crs, col, nib_vld, txen, m_crs, m_col, en_q, last_en, txc_q;
    logic [3:0] txd, nib, d_q, m_nib;
    logic       exp_txc;
    int failures, num_checks, cyc, on_t, off_t, col_on, col_off, val_t, len, gap;
    mii_tx_10m_carrier_sqe DUT (.SYS_CLK(sys_clk), .RST(rst), .TXEN(txen), .TXD(txd), .TXC(txc),
        .CRS(crs), .COL(col), .SQE_TEST_EN(sqe_en), .TX_NIBBLE(nib), .TX_NIBBLE_VALID(nib_vld));
    mac_tx_model MAC (.txc(txc), .txen(txen), .txd(txd));
    always #5 sys_clk = ~sys_clk;
    task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Reference model: times counted from the capture edge of each TXC period
    always @(posedge sys_clk) begin
        if (rst) begin
            {on_t, off_t, col_on, col_off, val_t} = {5{-32'sd1}};
            {m_crs, m_col, last_en, txc_q} = 4'h0;
        end else begin
            cyc++;
            if (cyc > 30000) begin
                failures++;
                report_and_stop();
            end
            if (cyc == on_t) m_crs = 1'b1;
            if (cyc == off_t) m_crs = 1'b0;
            if (cyc == col_on) m_col = 1'b1;
            if (cyc == col_off) m_col = 1'b0;
            // TXC first rises at the first edge after reset
            exp_txc = (cyc - 2) % mii_tx_pkg::TXC_PERIOD_CYC < mii_tx_pkg::TXC_HIGH_CYC;
            check("txc", {3'h0, txc}, {3'h0, exp_txc && cyc >= 2});
            check("crs", {3'h0, crs}, {3'h0, m_crs});
            check("col", {3'h0, col}, {3'h0, m_col});
            check("valid", {3'h0, nib_vld}, {3'h0, cyc == val_t});
            if (cyc == val_t) check("nibble", nib, m_nib);
            if (txc && !txc_q) begin
                if (en_q) begin
                    val_t = cyc + 1;
                    m_nib = d_q;
                end
                if (en_q && !last_en) begin
                    on_t = cyc + 41;
                    // A fall due at this very edge still happens
                    if (off_t > cyc + 1) off_t = -1;
                end
                if (!en_q && last_en) begin
                    off_t = cyc + 81;
                    if (on_t > cyc + 1) on_t = -1;
                    // A pending heartbeat is never restarted
                    if (sqe_en && cyc >= col_off) begin
                        col_on = cyc + 251;
                        col_off = cyc + 351;
                    end
                end
                last_en = en_q;
            end
            txc_q = txc;
            en_q = txen;
            d_q = txd;
        end
    end
    initial begin
        {sys_clk, rst, sqe_en} = 3'h2;
        {failures, num_checks, cyc} = 0;
        void'($urandom(32'hE74B7CC7));
        repeat (10) @(posedge sys_clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            // One-nibble frames and two-period gaps make CRS events coincide
            for (int f = 0; f < 6; f++) begin
                len = 1 + $urandom_range(4);
                gap = $urandom_range(1) ? 1 : 2 + $urandom_range(8);
                repeat (len) MAC.q.push_back({1'b1, 4'($urandom)});
                repeat (gap) MAC.q.push_back({1'b0, 4'($urandom)});
            end
            repeat (12) MAC.q.push_back({1'b0, 4'($urandom)});
            wait (MAC.q.size() == 0);
            @(posedge sys_clk);
            #2 sqe_en = ~sqe_en;
        end
        repeat (500) @(posedge sys_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
